// ### common/lmc_pkg.sv
// Contract
// - Channel goes normal on its command, or when chip enters software flash mode.
// - Normal mode enables both transmit onto bus and receive to receive output.
// - Two slopes: low slope for 10.4 kBaud, normal slope for 20 kBaud.
// - One chip-wide slope selection drives every channel at once.
// - Slope resets low; slope writes are taken only in chip normal mode.
// - Off mode: no transmit, receive or wake; left by command, flash mode entry or fail-safe.
// - Off selectable in chip normal, stop, sleep; forced in chip init.
// - Wake-capable selectable in stop, sleep, restart, normal; forced in fail-safe.
// - After a wake, wake-capable needs prior normal, receive-only or off.
// - Wake in sleep: chip to restart, supply up, receive low, flag set.
// - Leaving sleep by bus wake never asserts the interrupt output.
// - Wake source readable at register address 000; host reads after receive low.
// - Wake in stop: flag set, receive output low, interrupt output low.
// - After a stop-mode wake the chip stays in stop mode.
// - Stop or normal wake drives interrupt low only when not masked.
// - Bus wake needs dominant activity longer than the bus wake filter time.
// - Three identical, independent channels, each with mode, flag, receive output.
// - Receive-only: driver off, bus level still passed to receive output.
// - Flash mode only in chip software flash mode; slope control bypassed.
package lmc_pkg;

  // ************************************************************
  // sizes and register map
  // ************************************************************
  localparam int          NUM_CH         = 3;
  localparam int          ADDR_W         = 3;
  localparam int          DATA_W         = 8;
  localparam logic [2:0]  ADDR_WAKE_IRQ  = 3'h0;
  localparam logic [2:0]  ADDR_CHIP_MODE = 3'h1;
  localparam logic [2:0]  ADDR_LIN_MODE0 = 3'h2;
  localparam logic [2:0]  ADDR_SLOPE     = 3'h5;
  localparam logic [2:0]  ADDR_IRQ_MASK  = 3'h6;
  localparam logic [2:0]  ADDR_LOCK_STAT = 3'h7;
  localparam int          SLOPE_BIT      = 0;
  localparam logic        SLOPE_RST      = 1'h0;
  localparam logic [2:0]  MASK_RST       = 3'h0;
  localparam logic [7:0]  RDATA_ZERO     = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int          CLK_MHZ            = 250;
  localparam int          BUS_WAKE_FILTER_NS = 30000;
  localparam int          WAKE_FILT_CYC      = (BUS_WAKE_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int          WAKE_CNT_W         = 16;

  // ************************************************************
  // modes
  // ************************************************************
  typedef enum logic [2:0] {
    CHIP_INIT     = 3'b000,
    CHIP_NORMAL   = 3'b001,
    CHIP_SLEEP    = 3'b010,
    CHIP_RESTART  = 3'b011,
    CHIP_STOP     = 3'b100,
    CHIP_FAILSAFE = 3'b101,
    CHIP_SWFLASH  = 3'b110
  } lmc_chip_t;

  typedef enum logic [2:0] {
    LIN_OFF    = 3'b000,
    LIN_WAKE   = 3'b001,
    LIN_NORMAL = 3'b010,
    LIN_RXONLY = 3'b011,
    LIN_FLASH  = 3'b100
  } lmc_lin_t;

  function automatic logic lin_mode_allowed(input logic [2:0] req, input lmc_chip_t chip);
    logic ok;
    ok = 1'b0;
    case (req)
      LIN_OFF:    ok = (chip == CHIP_NORMAL) || (chip == CHIP_STOP) || (chip == CHIP_SLEEP);
      LIN_WAKE:   ok = (chip == CHIP_NORMAL) || (chip == CHIP_STOP) || (chip == CHIP_SLEEP)
                       || (chip == CHIP_RESTART);
      LIN_NORMAL: ok = (chip == CHIP_NORMAL) || (chip == CHIP_SWFLASH);
      LIN_RXONLY: ok = (chip == CHIP_NORMAL);
      LIN_FLASH:  ok = (chip == CHIP_SWFLASH);
      default:    ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic chip_code_ok(input logic [2:0] code);
    return (code != CHIP_INIT) && (code <= CHIP_SWFLASH);
  endfunction

endpackage

// ### src/lmc_wake_filter.sv
`timescale 1ns/100ps
module lmc_wake_filter
#(
  parameter int unsigned P_FILT_CYC = lmc_pkg::WAKE_FILT_CYC
)
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_en,
  input  wire logic i_bus,
  output logic      o_wake
);
  import lmc_pkg::*;

  logic [WAKE_CNT_W-1:0] cnt;
  logic                  qual;

  // ************************************************************
  // dominant length count
  // ************************************************************
  // wake fires on the return to recessive, so a bus shorted low never wakes
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cnt <= '0;
    else if (!i_en || i_bus)
      cnt <= '0;
    else if (!qual)
      cnt <= cnt + 1'b1;
  end

  assign qual = (cnt >= WAKE_CNT_W'(P_FILT_CYC));

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_wake <= 1'b0;
    else
      o_wake <= i_en && i_bus && qual;
  end

endmodule // lmc_wake_filter

// ### src/lmc_chan_ctrl.sv
`timescale 1ns/100ps
module lmc_chan_ctrl
(
  input  wire logic            i_clk,
  input  wire logic            i_nrst,
  input  wire lmc_pkg::lmc_chip_t i_chip,
  input  wire logic            i_flash_entry,
  input  wire logic            i_cmd_vld,
  input  wire logic [2:0]      i_cmd_mode,
  input  wire logic            i_wake,
  output lmc_pkg::lmc_lin_t    o_mode,
  output logic                 o_lock
);
  import lmc_pkg::*;

  lmc_lin_t next_mode;
  logic     cmd_ok;

  assign cmd_ok = i_cmd_vld && lin_mode_allowed(i_cmd_mode, i_chip)
                  && !((i_cmd_mode == LIN_WAKE) && o_lock);

  always_comb
  begin
    next_mode = o_mode;
    case (i_chip)
      CHIP_INIT:     next_mode = LIN_OFF;
      CHIP_FAILSAFE: next_mode = LIN_WAKE;
      default:
      begin
        if (i_flash_entry)
          next_mode = LIN_NORMAL;
        else if (cmd_ok)
          next_mode = lmc_lin_t'(i_cmd_mode);
        else if ((o_mode == LIN_FLASH) && (i_chip != CHIP_SWFLASH))
          next_mode = LIN_NORMAL;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_mode <= LIN_OFF;
    else
      o_mode <= next_mode;
  end

  // lock kept while wake capable or in flash; released only by off, normal or receive-only as next mode
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_lock <= 1'b0;
    else if (i_wake)
      o_lock <= 1'b1;
    else if ((next_mode == LIN_OFF) || (next_mode == LIN_NORMAL) || (next_mode == LIN_RXONLY))
      o_lock <= 1'b0;
  end

endmodule // lmc_chan_ctrl

// ### src/lmc_top.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
module lmc_top
#(
  parameter int unsigned P_WAKE_FILT_CYC = lmc_pkg::WAKE_FILT_CYC
)
(
  input  wire logic                        I_REF_CLK,
  input  wire logic                        I_NRST,
  input  wire logic [lmc_pkg::ADDR_W-1:0]  I_ADDR,
  input  wire logic [lmc_pkg::DATA_W-1:0]  I_WDATA,
  input  wire logic                        I_WR,
  input  wire logic                        I_RD,
  input  wire logic                        I_FAIL_SAFE,
  input  wire logic [lmc_pkg::NUM_CH-1:0]  I_TXD,
  input  wire logic [lmc_pkg::NUM_CH-1:0]  I_LIN_BUS,
  output logic      [lmc_pkg::DATA_W-1:0]  O_RDATA,
  output logic      [lmc_pkg::NUM_CH-1:0]  O_RXD,
  output logic      [lmc_pkg::NUM_CH-1:0]  O_LIN_DRV,
  output logic      [lmc_pkg::NUM_CH-1:0]  O_SLOPE_BYPASS,
  output logic                             O_SLOPE_NORMAL,
  output logic                             O_INT_N,
  output logic                             O_UC_SUPPLY_EN,
  output logic      [2:0]                  O_CHIP_MODE
);
  import lmc_pkg::*;

  lmc_chip_t          chip;
  lmc_chip_t          next_chip;
  lmc_chip_t          chip_prev;
  logic               flash_entry;
  lmc_lin_t           mode      [NUM_CH];
  logic [NUM_CH-1:0]  lock;
  logic [NUM_CH-1:0]  wake;
  logic [NUM_CH-1:0]  cmd_vld;
  logic [NUM_CH-1:0]  wake_flag;
  logic [NUM_CH-1:0]  int_pend;
  logic [NUM_CH-1:0]  irq_mask;
  logic [NUM_CH-1:0]  flag_clr;
  logic               slope;
  logic [DATA_W-1:0]  next_rdata;
  logic               wr_chip;

  // ************************************************************
  // chip operating mode
  // ************************************************************
  assign wr_chip = I_WR && (I_ADDR == ADDR_CHIP_MODE) && chip_code_ok(I_WDATA[2:0]);

  // fail-safe first, then a wake out of sleep or fail-safe, then software
  always_comb
  begin
    next_chip = chip;
    if (I_FAIL_SAFE)
      next_chip = CHIP_FAILSAFE;
    else if ((|wake) && ((chip == CHIP_SLEEP) || (chip == CHIP_FAILSAFE)))
      next_chip = CHIP_RESTART;
    else if (wr_chip)
      next_chip = lmc_chip_t'(I_WDATA[2:0]);
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      chip      <= CHIP_INIT;
      chip_prev <= CHIP_INIT;
    end
    else
    begin
      chip      <= next_chip;
      chip_prev <= chip;
    end
  end

  assign flash_entry = (chip == CHIP_SWFLASH) && (chip_prev != CHIP_SWFLASH);

  // ************************************************************
  // channels
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      // mode command acts only on the full write cycle
      assign cmd_vld[g] = I_WR && (I_ADDR == ADDR_W'(ADDR_LIN_MODE0 + g));

      lmc_wake_filter #(
        .P_FILT_CYC (P_WAKE_FILT_CYC)
      ) u_filt (
        .i_clk  (I_REF_CLK),
        .i_nrst (I_NRST),
        .i_en   (mode[g] == LIN_WAKE),
        .i_bus  (I_LIN_BUS[g]),
        .o_wake (wake[g])
      );

      lmc_chan_ctrl u_ctrl (
        .i_clk         (I_REF_CLK),
        .i_nrst        (I_NRST),
        .i_chip        (chip),
        .i_flash_entry (flash_entry),
        .i_cmd_vld     (cmd_vld[g]),
        .i_cmd_mode    (I_WDATA[2:0]),
        .i_wake        (wake[g]),
        .o_mode        (mode[g]),
        .o_lock        (lock[g])
      );

      always_ff @(posedge I_REF_CLK or negedge I_NRST)
      begin
        if (!I_NRST)
        begin
          O_RXD[g]          <= 1'b1;
          O_LIN_DRV[g]      <= 1'b0;
          O_SLOPE_BYPASS[g] <= 1'b0;
        end
        else
        begin
          case (mode[g])
            LIN_NORMAL, LIN_FLASH, LIN_RXONLY: O_RXD[g] <= I_LIN_BUS[g];
            LIN_WAKE:                          O_RXD[g] <= !lock[g];
            default:                           O_RXD[g] <= 1'b1;
          endcase
          // tx is active low; drive the bus dominant only in transmitting modes
          O_LIN_DRV[g]      <= ((mode[g] == LIN_NORMAL) || (mode[g] == LIN_FLASH)) && !I_TXD[g];
          O_SLOPE_BYPASS[g] <= (mode[g] == LIN_FLASH);
        end
      end
    end
  endgenerate

  // ************************************************************
  // wake flags and interrupt
  // ************************************************************
  assign flag_clr = (I_WR && (I_ADDR == ADDR_WAKE_IRQ)) ? I_WDATA[NUM_CH-1:0] : '0;

  // a wake in the clearing cycle survives the clear
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      wake_flag <= '0;
    else
      wake_flag <= (wake_flag & ~flag_clr) | wake;
  end

  // only stop and normal wakes may pull the interrupt; sleep wakes never do
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      int_pend <= '0;
    else if ((chip == CHIP_STOP) || (chip == CHIP_NORMAL))
      int_pend <= (int_pend & ~flag_clr) | wake;
    else
      int_pend <= int_pend & ~flag_clr;
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_INT_N <= 1'b1;
    else
      O_INT_N <= !(|(int_pend & ~irq_mask));
  end

  // ************************************************************
  // slope, mask and chip-level outputs
  // ************************************************************
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      slope <= SLOPE_RST;
    else if (I_WR && (I_ADDR == ADDR_SLOPE) && (chip == CHIP_NORMAL))
      slope <= I_WDATA[SLOPE_BIT];
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      irq_mask <= MASK_RST;
    else if (I_WR && (I_ADDR == ADDR_IRQ_MASK))
      irq_mask <= I_WDATA[NUM_CH-1:0];
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_SLOPE_NORMAL <= SLOPE_RST;
      O_UC_SUPPLY_EN <= 1'b1;
      O_CHIP_MODE    <= CHIP_INIT;
    end
    else
    begin
      O_SLOPE_NORMAL <= slope;
      O_UC_SUPPLY_EN <= (chip != CHIP_SLEEP);
      O_CHIP_MODE    <= chip;
    end
  end

  // ************************************************************
  // register read
  // ************************************************************
  always_comb
  begin
    next_rdata = RDATA_ZERO;
    case (I_ADDR)
      ADDR_WAKE_IRQ:  next_rdata[NUM_CH-1:0] = wake_flag;
      ADDR_CHIP_MODE: next_rdata[2:0]        = chip;
      ADDR_SLOPE:     next_rdata[SLOPE_BIT]  = slope;
      ADDR_IRQ_MASK:  next_rdata[NUM_CH-1:0] = irq_mask;
      ADDR_LOCK_STAT: next_rdata[NUM_CH-1:0] = lock;
      default:
      begin
        for (int i = 0; i < NUM_CH; i++)
          if (I_ADDR == ADDR_W'(ADDR_LIN_MODE0 + i))
            next_rdata[2:0] = mode[i];
      end
    endcase
  end

  // read data stand one cycle only, zero otherwise
  always_ff @(posedge I_REF_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      O_RDATA <= RDATA_ZERO;
    else if (I_RD)
      O_RDATA <= next_rdata;
    else
      O_RDATA <= RDATA_ZERO;
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_NRST);

  sequence s_enter_flash;
    (chip != CHIP_SWFLASH) ##1 (chip == CHIP_SWFLASH);
  endsequence

  sequence s_stop_wake;
    (chip == CHIP_STOP) && wake[0] && !irq_mask[0] && !I_FAIL_SAFE;
  endsequence

  a_init_forces_off: assert property ((chip == CHIP_INIT) |=> (mode[0] == LIN_OFF) && (mode[2] == LIN_OFF))
    else $error("channel not off in init mode");

  a_failsafe_wake: assert property ((chip == CHIP_FAILSAFE) |=> (mode[1] == LIN_WAKE))
    else $error("channel not wake capable in fail-safe");

  a_flash_entry_normal: assert property (s_enter_flash |=> (mode[0] == LIN_NORMAL))
    else $error("channel not normal after flash entry");

  a_slope_guard: assert property ((I_WR && (I_ADDR == ADDR_SLOPE) && (chip != CHIP_NORMAL)) |=> $stable(slope))
    else $error("slope changed outside chip normal");

  a_sleep_to_restart: assert property ((chip == CHIP_SLEEP) && (|wake) && !I_FAIL_SAFE
                                        |=> (chip == CHIP_RESTART) ##1 O_UC_SUPPLY_EN)
    else $error("sleep wake did not reach restart");

  a_sleep_no_int: assert property ((chip == CHIP_SLEEP) && (int_pend == '0) && !I_FAIL_SAFE
                                    |=> (int_pend == '0) ##1 O_INT_N)
    else $error("interrupt raised by sleep wake");

  a_stop_wake_int: assert property ((s_stop_wake and !I_WR) |=> int_pend[0] ##1 !O_INT_N)
    else $error("stop wake did not pull interrupt");

  a_stop_stays: assert property ((chip == CHIP_STOP) && (|wake) && !I_FAIL_SAFE && !wr_chip
                                  |=> (chip == CHIP_STOP))
    else $error("chip left stop mode on wake");

  a_masked_quiet: assert property ((int_pend & ~irq_mask) == '0 |=> O_INT_N)
    else $error("masked wake pulled interrupt");

  a_wake_flag_rx: assert property (wake[0] && (mode[0] == LIN_WAKE) |=> wake_flag[0] && lock[0] ##1 !O_RXD[0])
    else $error("wake flag or receive low missing");

  a_rxonly_path: assert property ((mode[2] == LIN_RXONLY)
                                   |=> !O_LIN_DRV[2] && (O_RXD[2] == $past(I_LIN_BUS[2])))
    else $error("receive-only drives or loses bus");

  a_wake_relock: assert property (lock[0] && (mode[0] == LIN_WAKE) && (chip != CHIP_FAILSAFE)
                                   && (chip != CHIP_INIT) |=> (mode[0] != LIN_OFF) || !lock[0])
    else $error("lock state inconsistent");

  // a legal normal command must land on the very next edge
  sequence s_normal_cmd;
    I_WR && (I_ADDR == ADDR_LIN_MODE0) && (I_WDATA[2:0] == LIN_NORMAL) && (chip == CHIP_NORMAL);
  endsequence

  a_normal_cmd: assert property (s_normal_cmd |=> (mode[0] == LIN_NORMAL))
    else $error("normal command not applied");

  a_normal_path: assert property ((mode[0] == LIN_NORMAL)
                                  |=> (O_RXD[0] == $past(I_LIN_BUS[0]))
                                  && (O_LIN_DRV[0] == !$past(I_TXD[0])))
    else $error("normal mode path broken");

  a_off_silent: assert property ((mode[1] == LIN_OFF) |=> !O_LIN_DRV[1] && O_RXD[1] && !wake[1])
    else $error("off channel active");

endmodule // lmc_top

// ### tb/lmc_bus_node.sv
`timescale 1ns/100ps
module lmc_bus_node
(
  input  wire logic [2:0] i_drv,
  input  wire logic [2:0] i_remote_dom,
  output logic      [2:0] o_bus
);
  // ************************************************************
  // wired-and lin lines, one per channel
  // ************************************************************
  // pull-up makes a released line recessive, never a stale level
  assign o_bus = ~(i_drv | i_remote_dom);
endmodule // lmc_bus_node

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import lmc_pkg::*;
  // short filter keeps the wake scenarios fast
  localparam int unsigned FILT = 8;
  typedef struct {
    logic [2:0] ch;
    logic [2:0] mode;
    logic [2:0] txd;
    logic [2:0] dom;
    logic [2:0] exp_mode;
    logic       exp_drv;
    logic       exp_rxd;
  } lmc_row_t;
  logic       clk        = 1'b0;
  logic       nrst       = 1'b0;
  logic [2:0] addr       = 3'h0;
  logic [7:0] wdata      = 8'h00;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic       fail_safe  = 1'b0;
  logic [2:0] txd        = 3'h7;
  logic [2:0] dom        = 3'h0;
  logic [2:0] bus;
  logic [7:0] rdata;
  logic [2:0] rxd;
  logic [2:0] drv;
  logic [2:0] bypass;
  logic [2:0] chip;
  logic       slope;
  logic       int_n;
  logic       supply;
  int         n_mismatch = 0;
  int         comparisons = 0;
  lmc_row_t   rows [7];

  always #2 clk = ~clk;

  lmc_top #(.P_WAKE_FILT_CYC(FILT)) lmc_top_i
  (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_FAIL_SAFE(fail_safe), .I_TXD(txd), .I_LIN_BUS(bus), .O_RDATA(rdata), .O_RXD(rxd),
    .O_LIN_DRV(drv), .O_SLOPE_BYPASS(bypass), .O_SLOPE_NORMAL(slope), .O_INT_N(int_n),
    .O_UC_SUPPLY_EN(supply), .O_CHIP_MODE(chip)
  );

  lmc_bus_node lmc_bus_node_i
  (
    .i_drv(drv),
    .i_remote_dom(dom),
    .o_bus(bus)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic conclude();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task pulse(input int ch, input int len);
    @(posedge clk);
    dom[ch] <= 1'b1;
    repeat (len) @(posedge clk);
    dom[ch] <= 1'b0;
  endtask

  task automatic wait_low(input int ch);
    int i;
    for (i = 0; i < 20 && rxd[ch] !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (rxd[ch] !== 1'b0)
    begin
      n_mismatch++;
      conclude();
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    settle(1);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    rows[0] = '{3'h0, LIN_NORMAL, 3'h6, 3'h0, LIN_NORMAL, 1'b1, 1'b0};
    rows[1] = '{3'h0, LIN_NORMAL, 3'h7, 3'h1, LIN_NORMAL, 1'b0, 1'b0};
    rows[2] = '{3'h0, LIN_NORMAL, 3'h7, 3'h0, LIN_NORMAL, 1'b0, 1'b1};
    rows[3] = '{3'h1, LIN_RXONLY, 3'h5, 3'h0, LIN_RXONLY, 1'b0, 1'b1};
    rows[4] = '{3'h1, LIN_RXONLY, 3'h7, 3'h2, LIN_RXONLY, 1'b0, 1'b0};
    rows[5] = '{3'h2, LIN_OFF, 3'h3, 3'h4, LIN_OFF, 1'b0, 1'b1};
    rows[6] = '{3'h2, LIN_FLASH, 3'h7, 3'h0, LIN_OFF, 1'b0, 1'b1};
    do_reset();
    chk({5'h00, chip}, 8'h00);
    chk({5'h00, rxd}, 8'h07);
    chk({5'h00, drv}, 8'h00);
    chk({7'h00, int_n}, 8'h01);
    wr_reg(ADDR_SLOPE, 8'h01);
    settle(3);
    chk({7'h00, slope}, 8'h00);
    wr_reg(ADDR_CHIP_MODE, {5'h00, CHIP_NORMAL});
    wr_reg(ADDR_SLOPE, 8'h01);
    settle(3);
    chk({7'h00, slope}, 8'h01);
    foreach (rows[k])
    begin
      wr_reg(ADDR_LIN_MODE0 + rows[k].ch, {5'h00, rows[k].mode});
      txd <= rows[k].txd;
      dom <= rows[k].dom;
      settle(3);
      chk({7'h00, drv[rows[k].ch]}, {7'h00, rows[k].exp_drv});
      chk({7'h00, rxd[rows[k].ch]}, {7'h00, rows[k].exp_rxd});
      rchk(ADDR_LIN_MODE0 + rows[k].ch, {5'h00, rows[k].exp_mode});
    end
    // stop-mode wake on channel 0, short glitch first
    wr_reg(ADDR_CHIP_MODE, {5'h00, CHIP_STOP});
    wr_reg(ADDR_SLOPE, 8'h00);
    wr_reg(ADDR_LIN_MODE0 + 3'h1, {5'h00, LIN_OFF});
    wr_reg(ADDR_LIN_MODE0, {5'h00, LIN_WAKE});
    settle(3);
    chk({7'h00, slope}, 8'h01);
    rchk(ADDR_LIN_MODE0 + 3'h1, 8'h00);
    pulse(0, FILT - 3);
    settle(8);
    rchk(ADDR_WAKE_IRQ, 8'h00);
    pulse(0, FILT + 2);
    wait_low(0);
    chk({7'h00, int_n}, 8'h00);
    chk({5'h00, chip}, {5'h00, CHIP_STOP});
    rchk(ADDR_WAKE_IRQ, 8'h01);
    rchk(ADDR_LOCK_STAT, 8'h01);
    wr_reg(ADDR_LIN_MODE0, {5'h00, LIN_WAKE});
    rchk(ADDR_LOCK_STAT, 8'h01);
    wr_reg(ADDR_LIN_MODE0, {5'h00, LIN_OFF});
    rchk(ADDR_LOCK_STAT, 8'h00);
    wr_reg(ADDR_LIN_MODE0, {5'h00, LIN_WAKE});
    rchk(ADDR_LIN_MODE0, 8'h01);
    wr_reg(ADDR_WAKE_IRQ, 8'h01);
    rchk(ADDR_WAKE_IRQ, 8'h00);
    chk({7'h00, int_n}, 8'h01);
    // masked wake keeps the interrupt line high
    wr_reg(ADDR_IRQ_MASK, 8'h01);
    pulse(0, FILT + 2);
    wait_low(0);
    settle(2);
    chk({7'h00, int_n}, 8'h01);
    rchk(ADDR_WAKE_IRQ, 8'h01);
    wr_reg(ADDR_WAKE_IRQ, 8'h01);
    wr_reg(ADDR_CHIP_MODE, {5'h00, CHIP_NORMAL});
    wr_reg(ADDR_LIN_MODE0, {5'h00, LIN_NORMAL});
    settle(3);
    chk({7'h00, rxd[0]}, 8'h01);
    // sleep wake on channel 1
    wr_reg(ADDR_LIN_MODE0 + 3'h1, {5'h00, LIN_WAKE});
    wr_reg(ADDR_CHIP_MODE, {5'h00, CHIP_SLEEP});
    settle(3);
    chk({7'h00, supply}, 8'h00);
    pulse(1, FILT + 2);
    wait_low(1);
    settle(2);
    chk({5'h00, chip}, {5'h00, CHIP_RESTART});
    chk({7'h00, supply}, 8'h01);
    chk({7'h00, int_n}, 8'h01);
    rchk(ADDR_WAKE_IRQ, 8'h02);
    // fail-safe forces wake capable everywhere
    @(posedge clk);
    fail_safe <= 1'b1;
    repeat (3) @(posedge clk);
    fail_safe <= 1'b0;
    #1;
    chk({5'h00, chip}, {5'h00, CHIP_FAILSAFE});
    rchk(ADDR_LIN_MODE0 + 3'h2, {5'h00, LIN_WAKE});
    wr_reg(ADDR_CHIP_MODE, {5'h00, CHIP_NORMAL});
    wr_reg(ADDR_CHIP_MODE, {5'h00, CHIP_SWFLASH});
    for (int c = 0; c < NUM_CH; c++)
      rchk(ADDR_LIN_MODE0 + 3'(c), {5'h00, LIN_NORMAL});
    wr_reg(ADDR_LIN_MODE0 + 3'h2, {5'h00, LIN_FLASH});
    settle(3);
    chk({5'h00, bypass}, 8'h04);
    wr_reg(ADDR_CHIP_MODE, {5'h00, CHIP_NORMAL});
    settle(3);
    chk({5'h00, bypass}, 8'h00);
    rchk(ADDR_LIN_MODE0 + 3'h2, {5'h00, LIN_NORMAL});
    // second reset in mid-run
    do_reset();
    chk({7'h00, slope}, 8'h00);
    chk({5'h00, chip}, 8'h00);
    rchk(ADDR_LIN_MODE0, 8'h00);
    conclude();
  end
endmodule // tb_top
